// ---- src/rq_ctrl_defs.svh ----
/*
 * Offsets, reset values and fixed counts of the requester request control block.
 * Assumes inclusion by its bare name; holds definitions only.
 */
`ifndef RQ_CTRL_DEFS_SVH
`define RQ_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define RQC_CTRL_OFFSET        8'h00
`define RQC_CREDIT_ADD_OFFSET  8'h04
`define RQC_STATUS_OFFSET      8'h08
`define RQC_ABORT_CNT_OFFSET   8'h0C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RQC_CTRL_ENABLE_BIT    0
`define RQC_ADD_NPH_LSB        0
`define RQC_ADD_NPD_LSB        8
`define RQC_STAT_OUT_LSB       0
`define RQC_STAT_NPH_LSB       8
`define RQC_STAT_NPD_LSB       16

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define RQC_CTRL_ENABLE_RESET  1'b1
`define RQC_TAG_COUNT          64
`define RQC_CREDIT_LAG_CYCLES  2

`endif

// ---- src/rq_ctrl_pkg.sv ----
/*
 * Types shared by the requester request control block and its tag table.
 * Assumes a 32-bit APB master and user logic on the same clock.
 */
package rq_ctrl_pkg;

    typedef logic [7:0] credit_t;
    typedef logic [5:0] tag_t;

    typedef enum logic [1:0] {
        PKT_IDLE = 2'b00,
        PKT_BODY = 2'b01
    } pkt_state_t;

    typedef struct packed {
        logic       abort;
        logic [3:0] seqNum;
        logic       isNp;
        logic       hasData;
        tag_t       userTag;
    } request_sideband_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic nullify;
        logic isNp;
        tag_t tag;
    } link_beat_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        ready;
        pkt_state_t  pkt;
        logic        pktHasData;
        logic        pktPosted;
        logic [3:0]  pktSeq;
        logic        abortSticky;
        tag_t        pktTag;
        logic        enable;
        credit_t     nph;
        credit_t     npd;
        logic [15:0] abortCount;
        link_beat_t  beat;
        tag_t        tagOut;
        logic        tagStrobe;
        logic [3:0]  seqOut;
        logic        seqStrobe;
        logic [1:0]  nphAvail;
        logic [1:0]  npdAvail;
        logic        errPulse;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } top_state_t;

endpackage

// ---- src/rq_tag_table.sv ----
/*
 * Split completion tag table: free map, lowest-free allocation, outstanding count.
 * Assumes the caller allocates only when a tag is free in internal mode.
 */
`timescale 1ns/10ps

module rq_tag_table #(
    parameter int DEPTH = 64
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             allocEn,
    input  wire logic             extMode,
    input  wire rq_ctrl_pkg::tag_t extTag,
    input  wire logic             releaseEn,
    input  wire rq_ctrl_pkg::tag_t releaseTag,
    output      rq_ctrl_pkg::tag_t nextTag,
    output      logic [6:0]       outstanding
);

    // Tag width bounds the table depth; the count is seven bits wide
    if (DEPTH < 1 || DEPTH > (1 << $bits(rq_ctrl_pkg::tag_t))) begin : g_bad_depth
        $error("tag table depth must be 1 to 64");
    end

    typedef struct packed {
        logic [DEPTH-1:0] freeMap;
        logic [6:0]       count;
    } table_state_t;

    table_state_t state_q;
    table_state_t state_d;

    function automatic rq_ctrl_pkg::tag_t lowestFree(input logic [DEPTH-1:0] map);
        rq_ctrl_pkg::tag_t idx;
        idx = 6'h00;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (map[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction

    logic             relValid;
    rq_ctrl_pkg::tag_t useTag;

    always_comb begin
        state_d  = state_q;
        useTag   = extMode ? extTag : lowestFree(state_q.freeMap);
        // A release of a tag that is not out is ignored, so the count cannot wrap below zero
        relValid = releaseEn && !state_q.freeMap[releaseTag];
        if (relValid) begin
            state_d.freeMap[releaseTag] = 1'b1;
        end
        if (allocEn) begin
            state_d.freeMap[useTag] = 1'b0;
        end
        state_d.count = 7'(state_q.count + {6'h00, allocEn} - {6'h00, relValid});
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q.freeMap <= '1;
            state_q.count   <= 7'h00;
        end else begin
            state_q <= state_d;
        end
    end

    assign nextTag     = extMode ? extTag : lowestFree(state_q.freeMap);
    assign outstanding = state_q.count;

endmodule

// ---- src/rq_request_ctrl.sv ----
/*
 * Requester request side control: abort handling, tag allocation, NP credit
 * reporting and posted order numbers, with an APB register slave.
 * Assumes user logic, completion logic and APB master all run on clk.
 */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "rq_ctrl_defs.svh"

module rq_request_ctrl #(
    parameter bit              external_tag_select = 1'b0,
    parameter bit              IS_ENDPOINT         = 1'b1,
    parameter int              TAG_DEPTH           = `RQC_TAG_COUNT,
    parameter rq_ctrl_pkg::credit_t NPH_INIT       = 8'h08,
    parameter rq_ctrl_pkg::credit_t NPD_INIT       = 8'h08
) (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire rq_ctrl_pkg::apb_req_t          apbReq,
    output      logic [31:0]                    prdata,
    output      logic                           pready,
    output      logic                           pslverr,
    input  wire logic                           request_stream_valid,
    input  wire logic                           request_stream_last,
    input  wire rq_ctrl_pkg::request_sideband_t request_sideband_bus,
    output      logic                           request_stream_ready,
    output      rq_ctrl_pkg::link_beat_t        linkBeat,
    input  wire logic                           cplEofAccept,
    input  wire logic                           cplFinalSplit,
    input  wire rq_ctrl_pkg::tag_t              cplTag,
    output      rq_ctrl_pkg::tag_t              allocated_tag_out,
    output      logic                           allocated_tag_strobe,
    output      logic [1:0]                     np_header_credit_avail,
    output      logic [1:0]                     np_data_credit_avail,
    output      logic [3:0]                     posted_order_number_out,
    output      logic                           posted_order_number_strobe,
    output      logic                           uncorrErrReport
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (TAG_DEPTH != `RQC_TAG_COUNT) begin : g_bad_depth
        $error("tag table depth must be 64");
    end
    if (`RQC_CREDIT_LAG_CYCLES != 2) begin : g_bad_lag
        $error("credit report pipeline is built for a lag of two");
    end

    rq_ctrl_pkg::top_state_t state_q;
    rq_ctrl_pkg::top_state_t state_d;

    rq_ctrl_pkg::tag_t nextTag;
    logic [6:0]        outstanding;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [1:0] creditCode(input rq_ctrl_pkg::credit_t c);
        return (c > 8'h03) ? 2'h3 : c[1:0];
    endfunction

    function automatic rq_ctrl_pkg::credit_t satAdd(input rq_ctrl_pkg::credit_t a,
                                                    input rq_ctrl_pkg::credit_t b);
        logic [8:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[8] ? 8'hFF : sum[7:0];
    endfunction

    // Whether a beat may be taken given the resources that stand after this edge
    function automatic logic canTake(input logic first, input logic isNp,
                                     input logic hasData, input rq_ctrl_pkg::credit_t nph,
                                     input rq_ctrl_pkg::credit_t npd, input logic full);
        logic ok;
        ok = 1'b1;
        if (first && isNp) begin
            ok = (nph != 8'h00) && (!hasData || npd != 8'h00);
            if (!external_tag_select && full) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // ------------------------------------------------------------------------
    // Tag table
    // ------------------------------------------------------------------------
    logic fire;
    logic firstBeat;
    logic npStart;
    logic cplRelease;

    assign fire       = request_stream_valid && state_q.ready;
    assign firstBeat  = (state_q.pkt == rq_ctrl_pkg::PKT_IDLE);
    assign npStart    = fire && firstBeat && request_sideband_bus.isNp;
    assign cplRelease = cplEofAccept && cplFinalSplit;

    rq_tag_table #(
        .DEPTH       (TAG_DEPTH)
    ) u_tags (
        .clk         (clk),
        .rst_n       (rst_n),
        .allocEn     (npStart),
        .extMode     (external_tag_select),
        .extTag      (request_sideband_bus.userTag),
        .releaseEn   (cplRelease),
        .releaseTag  (cplTag),
        .nextTag     (nextTag),
        .outstanding (outstanding)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic                 setup;
    logic                 wrDone;
    logic                 pktData;
    logic                 abortNow;
    logic                 firstNext;
    logic                 fullNext;
    logic [6:0]           outNext;
    rq_ctrl_pkg::credit_t addNph;
    rq_ctrl_pkg::credit_t addNpd;
    rq_ctrl_pkg::tag_t    beatTag;

    always_comb begin
        state_d   = state_q;
        setup     = apbReq.psel && !apbReq.penable;
        wrDone    = apbReq.psel && apbReq.penable && state_q.pready && apbReq.pwrite;
        addNph    = 8'h00;
        addNpd    = 8'h00;
        pktData   = firstBeat ? request_sideband_bus.hasData : state_q.pktHasData;
        abortNow  = fire && request_sideband_bus.abort && pktData;
        beatTag   = firstBeat ? nextTag : state_q.pktTag;

        // Packet tracking and the link beat
        state_d.beat = '0;
        if (fire) begin
            state_d.beat.valid   = 1'b1;
            state_d.beat.last    = request_stream_last;
            state_d.beat.nullify = state_q.abortSticky || abortNow;
            state_d.beat.isNp    = firstBeat ? request_sideband_bus.isNp : !state_q.pktPosted;
            state_d.beat.tag     = beatTag;
            if (firstBeat) begin
                state_d.pktHasData = request_sideband_bus.hasData;
                state_d.pktPosted  = !request_sideband_bus.isNp;
                state_d.pktSeq     = request_sideband_bus.seqNum;
                state_d.pktTag     = nextTag;
            end
            if (request_stream_last) begin
                state_d.pkt         = rq_ctrl_pkg::PKT_IDLE;
                state_d.abortSticky = 1'b0;
            end else begin
                state_d.pkt         = rq_ctrl_pkg::PKT_BODY;
                state_d.abortSticky = state_q.abortSticky || abortNow;
            end
        end

        // Abort report at the packet's end
        state_d.errPulse = IS_ENDPOINT && fire && request_stream_last
                           && (state_q.abortSticky || abortNow);

        // Tag report in internal tag mode, one strobe per NP request in request order
        state_d.tagStrobe = npStart && !external_tag_select;
        if (npStart) begin
            state_d.tagOut = nextTag;
        end

        // Posted number reported as its last beat reaches the link merge point,
        // which is where completions join; later completions queue behind it
        state_d.seqStrobe = 1'b0;
        if (fire && request_stream_last
            && (firstBeat ? !request_sideband_bus.isNp : state_q.pktPosted)) begin
            state_d.seqStrobe = 1'b1;
            state_d.seqOut    = firstBeat ? request_sideband_bus.seqNum
                                          : state_q.pktSeq;
        end

        // APB slave, zero wait states: answer prepared in the setup cycle
        state_d.pready  = setup;
        state_d.pslverr = 1'b0;
        if (setup) begin
            state_d.prdata = 32'h0000_0000;
            case (apbReq.paddr)
                `RQC_CTRL_OFFSET: begin
                    state_d.prdata[`RQC_CTRL_ENABLE_BIT] = state_q.enable;
                end
                `RQC_CREDIT_ADD_OFFSET: begin
                    state_d.prdata = 32'h0000_0000;
                end
                `RQC_STATUS_OFFSET: begin
                    state_d.prdata[`RQC_STAT_OUT_LSB +: 7] = outstanding;
                    state_d.prdata[`RQC_STAT_NPH_LSB +: 8] = state_q.nph;
                    state_d.prdata[`RQC_STAT_NPD_LSB +: 8] = state_q.npd;
                end
                `RQC_ABORT_CNT_OFFSET: begin
                    state_d.prdata[15:0] = state_q.abortCount;
                end
                default: begin
                    state_d.pslverr = 1'b1;
                end
            endcase
        end
        if (wrDone) begin
            case (apbReq.paddr)
                `RQC_CTRL_OFFSET: begin
                    state_d.enable = apbReq.pwdata[`RQC_CTRL_ENABLE_BIT];
                end
                `RQC_CREDIT_ADD_OFFSET: begin
                    addNph = apbReq.pwdata[`RQC_ADD_NPH_LSB +: 8];
                    addNpd = apbReq.pwdata[`RQC_ADD_NPD_LSB +: 8];
                end
                `RQC_ABORT_CNT_OFFSET: begin
                    state_d.abortCount = 16'h0000;
                end
                default: begin
                    state_d.abortCount = state_q.abortCount;
                end
            endcase
        end
        // Counting after the clear keeps an abort that lands on the clear
        if (state_d.errPulse || (fire && request_stream_last && !IS_ENDPOINT
                                 && (state_q.abortSticky || abortNow))) begin
            state_d.abortCount = 16'(state_d.abortCount + 16'h0001);
        end

        // Credits: consumed on the descriptor beat, returned by software
        state_d.nph = satAdd(8'(state_q.nph - {7'h00, npStart}), addNph);
        state_d.npd = satAdd(8'(state_q.npd - {7'h00, npStart
                                               && request_sideband_bus.hasData}), addNpd);

        // Second stage of the lag: counters move one edge after the beat,
        // the encoded outputs one edge later
        state_d.nphAvail = creditCode(state_q.nph);
        state_d.npdAvail = creditCode(state_q.npd);

        // Ready for the next cycle; a held beat is judged as it stands, an
        // unseen one as the costliest NP request so nothing slips past a limit
        outNext   = 7'(outstanding + {6'h00, npStart}
                       - {6'h00, cplRelease});
        fullNext  = (outNext >= 7'(TAG_DEPTH));
        firstNext = (state_d.pkt == rq_ctrl_pkg::PKT_IDLE);
        if (request_stream_valid && !fire) begin
            state_d.ready = canTake(firstNext, request_sideband_bus.isNp,
                                    request_sideband_bus.hasData,
                                    state_d.nph, state_d.npd, fullNext);
        end else begin
            state_d.ready = canTake(firstNext, 1'b1, 1'b1,
                                    state_d.nph, state_d.npd, fullNext);
        end
        state_d.ready = state_d.ready && state_d.enable;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q        <= '0;
            state_q.pkt    <= rq_ctrl_pkg::PKT_IDLE;
            state_q.enable <= `RQC_CTRL_ENABLE_RESET;
            state_q.nph    <= NPH_INIT;
            state_q.npd    <= NPD_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata                     = state_q.prdata;
    assign pready                     = state_q.pready;
    assign pslverr                    = state_q.pslverr;
    assign request_stream_ready       = state_q.ready;
    assign linkBeat                   = state_q.beat;
    assign allocated_tag_out          = state_q.tagOut;
    assign allocated_tag_strobe       = state_q.tagStrobe;
    assign np_header_credit_avail     = state_q.nphAvail;
    assign np_data_credit_avail       = state_q.npdAvail;
    assign posted_order_number_out    = state_q.seqOut;
    assign posted_order_number_strobe = state_q.seqStrobe;
    assign uncorrErrReport            = state_q.errPulse;

endmodule

// ---- tb/rq_request_ctrl_monitor.sv ----
/* Checker of the request control block's stream, tag, order and APB outputs.
   Assumes it is bound into the block's top module; one clock domain. */
`timescale 1ns/10ps
module rq_request_ctrl_monitor (
    input wire logic                           clk,
    input wire logic                           rst_n,
    input wire rq_ctrl_pkg::apb_req_t          apbReq,
    input wire logic                           pready,
    input wire logic                           request_stream_valid,
    input wire logic                           request_stream_last,
    input wire rq_ctrl_pkg::request_sideband_t request_sideband_bus,
    input wire logic                           request_stream_ready,
    input wire rq_ctrl_pkg::link_beat_t        linkBeat,
    input wire logic                           allocated_tag_strobe,
    input wire rq_ctrl_pkg::tag_t              allocated_tag_out,
    input wire logic [3:0]                     posted_order_number_out,
    input wire logic                           posted_order_number_strobe,
    input wire logic                           uncorrErrReport
);
    logic       inPkt_q, data_q, sticky_q;
    logic [3:0] seq_q;
    wire        taken = request_stream_valid && request_stream_ready;
    // Packet context is only valid on the first beat, so keep it here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            inPkt_q  <= 1'b0;
            sticky_q <= 1'b0;
        end else begin
            if (taken) inPkt_q <= !request_stream_last;
            if (taken && !inPkt_q) {data_q, seq_q} <= {request_sideband_bus.hasData,
                request_sideband_bus.seqNum};
            if (linkBeat.valid) sticky_q <= linkBeat.nullify && !linkBeat.last;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence npFirst_s;
        taken && !inPkt_q && request_sideband_bus.isNp;
    endsequence
    sequence abortTaken_s;
        taken && request_sideband_bus.abort && (inPkt_q ? data_q : request_sideband_bus.hasData);
    endsequence
    sequence postedEnd_s;
        linkBeat.valid && linkBeat.last && !linkBeat.isNp;
    endsequence
    link_copy_a: assert property (taken |=>
        linkBeat.valid && linkBeat.last == $past(request_stream_last))
        else $error("link beat not copied");
    abort_null_a: assert property (abortTaken_s |=> linkBeat.nullify)
        else $error("aborted beat not nullified");
    sticky_null_a: assert property (linkBeat.valid && sticky_q |-> linkBeat.nullify)
        else $error("abort dropped before packet end");
    err_report_a: assert property (linkBeat.valid && linkBeat.last && linkBeat.nullify
        |-> uncorrErrReport) else $error("aborted packet not reported");
    err_cause_a: assert property (uncorrErrReport |->
        linkBeat.valid && linkBeat.last && linkBeat.nullify) else $error("spurious error");
    tag_strobe_a: assert property (npFirst_s |=> allocated_tag_strobe &&
        linkBeat.isNp && linkBeat.tag == allocated_tag_out)
        else $error("no tag strobe after request");
    seq_report_a: assert property (postedEnd_s |-> posted_order_number_strobe &&
        posted_order_number_out == seq_q) else $error("order number wrong or missing");
    apb_answer_a: assert property (apbReq.psel && !apbReq.penable |=> pready)
        else $error("register access not answered");
endmodule

// ---- tb/rq_user_model.sv ----
/* User-side source of the request stream; records handed-out tags.
   Assumes send and idle are called from one process at clock edges. */
`timescale 1ns/10ps
module rq_user_model (
    input  wire logic                           clk,
    input  wire logic                           request_stream_ready,
    input  wire logic                           allocated_tag_strobe,
    input  wire rq_ctrl_pkg::tag_t              allocated_tag_out,
    output      logic                           request_stream_valid,
    output      logic                           request_stream_last,
    output      rq_ctrl_pkg::request_sideband_t request_sideband_bus
);
    rq_ctrl_pkg::tag_t tags[$];
    initial begin
        request_stream_valid = 1'b0;
        request_stream_last  = 1'b0;
        request_sideband_bus = '0;
    end
    always @(posedge clk) if (allocated_tag_strobe === 1'b1) tags.push_back(allocated_tag_out);
    // Beat held whole until taken; abort raised only on beat ab
    task automatic send(input logic np, input logic dat, input int n, input int ab,
                        input logic [3:0] sq);
        for (int i = 0; i < n; i++) begin
            request_stream_valid <= 1'b1;
            request_stream_last  <= (i == n - 1);
            request_sideband_bus <= '{(i == ab), sq, np, dat, 6'h00};
            do @(posedge clk); while (request_stream_ready !== 1'b1);
        end
    endtask
    // Released lines show inverted values; abort stays low outside beats
    task automatic idle();
        request_stream_valid <= 1'b0;
        request_stream_last  <= ~request_stream_last;
        request_sideband_bus <= ~request_sideband_bus & 13'h0FFF;
    endtask
endmodule

// ---- tb/requester_request_side_control_tb.sv ----
/* Bench top: clock, reset, APB master, completion release and verdict.
   Assumes the package, checker and user model are compiled first. */
`timescale 1ns/10ps
module requester_request_side_control_tb;
    logic                  clk, rst_n, pready, pslverr, valid, last, ready;
    logic                  cplEof, cplFinal, tagStb, seqStb, errRep;
    logic [1:0]            nphAv, npdAv;
    logic [3:0]            seqOut;
    logic [31:0]           prdata;
    rq_ctrl_pkg::tag_t     cplTag, tagOut;
    rq_ctrl_pkg::apb_req_t apbReq;
    rq_ctrl_pkg::request_sideband_t sb;
    rq_ctrl_pkg::link_beat_t        linkBeat;
    int                    mismatches, checkCount, cycles;

    rq_request_ctrl #(.NPH_INIT(8'h02), .NPD_INIT(8'h01)) u_dut (
        .clk(clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .request_stream_valid(valid), .request_stream_last(last),
        .request_sideband_bus(sb), .request_stream_ready(ready), .linkBeat(linkBeat),
        .cplEofAccept(cplEof), .cplFinalSplit(cplFinal), .cplTag(cplTag),
        .allocated_tag_out(tagOut), .allocated_tag_strobe(tagStb),
        .np_header_credit_avail(nphAv), .np_data_credit_avail(npdAv),
        .posted_order_number_out(seqOut), .posted_order_number_strobe(seqStb),
        .uncorrErrReport(errRep));
    rq_user_model u_user (
        .clk(clk), .request_stream_ready(ready), .allocated_tag_strobe(tagStb),
        .allocated_tag_out(tagOut), .request_stream_valid(valid),
        .request_stream_last(last), .request_sideband_bus(sb));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Zero wait states expected, but the wait is open until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        apbReq <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        apbReq <= '0;
        @(posedge clk);
    endtask
    task automatic freeTag(input rq_ctrl_pkg::tag_t t, input logic fin);
        {cplTag, cplEof, cplFinal} <= {t, 1'b1, fin};
        @(posedge clk);
        cplEof <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        logic [31:0]       r;
        logic              e;
        logic [3:0]        sq;
        rq_ctrl_pkg::tag_t rt;
        {rst_n, apbReq, cplEof, cplFinal, cplTag, mismatches, checkCount, cycles} = '0;
        void'($urandom(32'h1B83));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(nphAv), 32'h2);
        check(32'(npdAv), 32'h1);
        u_user.send(1'b1, 1'b1, 1, -1, 4'h0);
        u_user.idle();
        @(posedge clk);
        check(32'(nphAv), 32'h2);
        @(posedge clk);
        check({nphAv, npdAv}, 32'h4);
        u_user.send(1'b1, 1'b0, 1, -1, 4'h0);
        u_user.idle();
        repeat (3) @(posedge clk);
        check({nphAv, npdAv}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            sq = 4'($urandom);
            u_user.send(1'b0, 1'b1, (i == 0) ? 3 : 2 + $urandom % 3,
                        (i == 0) ? 1 : -1, sq);
            u_user.idle();
            repeat (3) @(posedge clk);
            check(32'(seqOut), 32'(sq));
        end
        fork
            u_user.send(1'b1, 1'b0, 1, -1, 4'h0);
        join_none
        repeat (8) @(posedge clk);
        check(32'(ready), 32'h0);
        apb(1'b1, 8'h04, 32'h0000_5050, r, e);
        wait fork;
        for (int i = 3; i < 64; i++) u_user.send(1'b1, 1'b0, 1, -1, 4'h0);
        u_user.idle();
        repeat (3) @(posedge clk);
        check(32'({nphAv, npdAv}), 32'hF);
        apb(1'b0, 8'h08, 32'h0, r, e);
        check(r & 32'h00FF_FF7F, 32'h0050_1240);
        fork
            u_user.send(1'b1, 1'b0, 1, -1, 4'h0);
        join_none
        repeat (8) @(posedge clk);
        check(32'(ready), 32'h0);
        rt = 6'($urandom);
        freeTag(rt, 1'b0);
        repeat (6) @(posedge clk);
        check(32'(ready), 32'h0);
        freeTag(rt, 1'b1);
        wait fork;
        u_user.idle();
        repeat (3) @(posedge clk);
        check(32'(u_user.tags.size()), 32'd65);
        for (int i = 0; i < 64; i++) check(32'(u_user.tags[i]), i);
        check(32'(u_user.tags[64]), 32'(rt));
        apb(1'b0, 8'h0C, 32'h0, r, e);
        check(r, 32'h1);
        apb(1'b0, 8'h10, 32'h0, r, e);
        check(r, 32'h0);
        check(32'(e), 32'h1);
        stop_test();
    end
endmodule

bind rq_request_ctrl rq_request_ctrl_monitor u_mon (.*);
